// [hw/ldct_pkg.sv]
// Constants, register map and enumerations for the three-channel down counter.
// Assumes a single 25 MHz clock domain and a simple strobe-based register port.
package ldct_pkg;

    // ========================================================================
    // Sizes
    localparam int NUM_CHANNELS = 3;
    localparam int COUNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 6;

    // ========================================================================
    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] CH_CTRL_OFS = 4'h0;
    localparam logic [3:0] CH_LOAD_OFS = 4'h4;
    localparam logic [3:0] CH_COUNT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] LINK_OFS = 8'h30;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h34;
    localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h38;
    localparam logic [ADDR_W-1:0] SWTRIG_OFS = 8'h3c;

    // ========================================================================
    // Channel control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_ACTION_LSB = 1;
    localparam int CTRL_ACTION_W = 2;
    localparam int CTRL_SINGLE_BIT = 3;
    localparam int CTRL_RETRIG_BIT = 4;
    localparam int CTRL_INTSRC_BIT = 5;

    // Status fields
    localparam int STATUS_OUT_LSB = 0;
    localparam int STATUS_RUN_LSB = 4;

    // ========================================================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [COUNT_W-1:0] LOAD_RESET = 16'h0000;

    // ========================================================================
    // Enumerations
    typedef enum logic [1:0] {
        PULSE_ON_TERMINAL,
        TOGGLE_ON_TERMINAL,
        HIGH_UNTIL_TERMINAL
    } output_action_e;

    typedef enum logic [1:0] {
        UNLINKED,
        LINK_TO_GATE,
        LINK_TO_TRIGGER,
        LINK_TO_CLOCK_INPUT
    } link_select_e;

endpackage

// [hw/down_counter_channel.sv]
// One down-counting channel with output action, reload and retrigger control.
// Assumes count, gate and trigger inputs are synchronous to mclk.
`timescale 1ns/1ps

module down_counter_channel
    import ldct_pkg::*;
#(
    parameter int WIDTH = COUNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration
    input wire logic enable,
    input wire logic [1:0] action,
    input wire logic single_run,
    input wire logic retrigger,
    input wire logic internal_src,
    input wire logic [WIDTH-1:0] init_count,
    // Signal inputs
    input wire logic count_in,
    input wire logic gate_in,
    input wire logic trig_in,
    // State and output
    output logic [WIDTH-1:0] count_q,
    output logic running,
    output logic out_q,
    output logic terminal_q
);

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} chan_state_e;

    // ========================================================================
    // Next-state logic
    chan_state_e state_q, state_d;
    logic [WIDTH-1:0] count_d;
    logic out_d, terminal_d;
    logic en_prev_q, src_prev_q, trig_prev_q;
    logic tick, trig_edge, start, reload;
    output_action_e act;

    assign act = output_action_e'(action);
    assign tick = internal_src | (count_in & ~src_prev_q);
    assign trig_edge = trig_in & ~trig_prev_q;
    assign start = enable & ~en_prev_q;
    assign reload = start | (retrigger & trig_edge);
    assign running = (state_q == ST_RUN);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        out_d = out_q;
        terminal_d = 1'b0;
        // A pulse output only lasts the single cycle after terminal count
        if (act != TOGGLE_ON_TERMINAL && act != HIGH_UNTIL_TERMINAL) begin
            out_d = 1'b0;
        end
        if (!enable) begin
            state_d = ST_IDLE;
            out_d = 1'b0;
        end else if (reload) begin
            state_d = ST_RUN;
            count_d = init_count;
            if (act == HIGH_UNTIL_TERMINAL) begin
                out_d = 1'b1;
            end
        end else if (state_q == ST_RUN && tick && gate_in) begin
            // Count zero also ends a run, so a zero load cannot wrap around
            if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                terminal_d = 1'b1;
                case (act)
                    TOGGLE_ON_TERMINAL: out_d = ~out_q;
                    HIGH_UNTIL_TERMINAL: out_d = 1'b0;
                    default: out_d = 1'b1;
                endcase
                if (single_run) begin
                    count_d = '0;
                    state_d = ST_DONE;
                end else begin
                    count_d = init_count;
                end
            end else begin
                count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // ========================================================================
    // Registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            count_q <= '0;
            out_q <= 1'b0;
            terminal_q <= 1'b0;
            en_prev_q <= 1'b0;
            src_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            out_q <= out_d;
            terminal_q <= terminal_d;
            en_prev_q <= enable;
            src_prev_q <= count_in;
            trig_prev_q <= trig_in;
        end
    end

endmodule // down_counter_channel

// [hw/linked_down_counter_trio.sv]
// Three linked down counters behind a simple strobe register port.
// Assumes pin inputs are synchronous to mclk and a single-cycle bus master.
`timescale 1ns/1ps

// Summary of operation
// - three channels, each configured on its own
// - pulse action gives one-clock high at terminal
// - toggle action inverts output at each terminal
// - high from counting start, low at terminal
// - auto reload restarts from initial count
// - single run stops after one cycle
// - retrigger event reloads initial count, continues
// - unlinked: channel 1 drives no other inputs
// - link to gate: channel 1 gates channel 2
// - link to trigger: channel 1 triggers channel 2
// - link to clock: channel 1 clocks channel 2
module linked_down_counter_trio
    import ldct_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS,
    parameter int WIDTH = COUNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    // Counter pins
    input wire logic [CHANNELS-1:0] count_in,
    input wire logic [CHANNELS-1:0] gate_in,
    input wire logic [CHANNELS-1:0] trig_in,
    output logic [CHANNELS-1:0] ctr_out
);

    // ========================================================================
    // Address decode
    logic [1:0] ch_sel;
    logic [3:0] ch_ofs;
    logic ch_hit;

    assign ch_sel = addr[5:4];
    assign ch_ofs = addr[3:0];
    assign ch_hit = (addr[ADDR_W-1:6] == '0) && (int'(ch_sel) < CHANNELS);

    // ========================================================================
    // Register file
    logic [CTRL_W-1:0] ctrl_q [CHANNELS];
    logic [CTRL_W-1:0] ctrl_d [CHANNELS];
    logic [WIDTH-1:0] load_q [CHANNELS];
    logic [WIDTH-1:0] load_d [CHANNELS];
    logic [1:0] link_q, link_d;
    logic [CHANNELS-1:0] flags_q, flags_d;
    logic [CHANNELS-1:0] swtrig_q, swtrig_d;
    logic [CHANNELS-1:0] terminal;
    logic [CHANNELS-1:0] running;
    logic [WIDTH-1:0] count [CHANNELS];

    always_comb begin
        link_d = link_q;
        swtrig_d = '0;
        // A terminal count in the same cycle as a clear keeps its flag set
        flags_d = flags_q;
        if (wr_en && addr == FLAGS_OFS) begin
            flags_d = flags_q & ~wdata[CHANNELS-1:0];
        end
        flags_d = flags_d | terminal;
        // The link is expected to be settled before channels 1 and 2 start;
        // changing it while they run glitches channel 2's inputs.
        if (wr_en && addr == LINK_OFS) begin
            link_d = wdata[1:0];
        end
        if (wr_en && addr == SWTRIG_OFS) begin
            swtrig_d = wdata[CHANNELS-1:0];
        end
        for (int i = 0; i < CHANNELS; i++) begin
            ctrl_d[i] = ctrl_q[i];
            load_d[i] = load_q[i];
            if (wr_en && ch_hit && int'(ch_sel) == i) begin
                if (ch_ofs == CH_CTRL_OFS) begin
                    ctrl_d[i] = wdata[CTRL_W-1:0];
                end
                if (ch_ofs == CH_LOAD_OFS) begin
                    load_d[i] = wdata[WIDTH-1:0];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_q <= UNLINKED;
            flags_q <= '0;
            swtrig_q <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                ctrl_q[i] <= CTRL_RESET;
                load_q[i] <= LOAD_RESET;
            end
        end else begin
            link_q <= link_d;
            flags_q <= flags_d;
            swtrig_q <= swtrig_d;
            for (int i = 0; i < CHANNELS; i++) begin
                ctrl_q[i] <= ctrl_d[i];
                load_q[i] <= load_d[i];
            end
        end
    end

    // ========================================================================
    // Read path: data valid in the cycle after the read strobe
    logic [DATA_W-1:0] rdata_d, rdata_q;

    always_comb begin
        rdata_d = '0;
        if (rd_en) begin
            if (ch_hit) begin
                case (ch_ofs)
                    CH_CTRL_OFS: rdata_d[CTRL_W-1:0] = ctrl_q[ch_sel];
                    CH_LOAD_OFS: rdata_d[WIDTH-1:0] = load_q[ch_sel];
                    CH_COUNT_OFS: rdata_d[WIDTH-1:0] = count[ch_sel];
                    default: rdata_d = '0;
                endcase
            end else begin
                case (addr)
                    LINK_OFS: rdata_d[1:0] = link_q;
                    STATUS_OFS: begin
                        rdata_d[STATUS_OUT_LSB +: CHANNELS] = ctr_out;
                        rdata_d[STATUS_RUN_LSB +: CHANNELS] = running;
                    end
                    FLAGS_OFS: rdata_d[CHANNELS-1:0] = flags_q;
                    default: rdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ========================================================================
    // Channels with link routing from channel 1 into channel 2
    link_select_e link;
    assign link = link_select_e'(link_q);

    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
            logic src_sel, gate_sel, trig_sel;

            always_comb begin
                src_sel = count_in[g];
                gate_sel = gate_in[g];
                trig_sel = trig_in[g] | swtrig_q[g];
                if (g == 1) begin
                    case (link)
                        LINK_TO_GATE: gate_sel = ctr_out[0];
                        LINK_TO_TRIGGER: trig_sel = ctr_out[0] | swtrig_q[g];
                        LINK_TO_CLOCK_INPUT: src_sel = ctr_out[0];
                        default: src_sel = count_in[g];
                    endcase
                end
            end

            down_counter_channel #(
                .WIDTH(WIDTH)
            ) u_chan (
                .mclk(mclk),
                .rst_n(rst_n),
                .enable(ctrl_q[g][CTRL_ENABLE_BIT]),
                .action(ctrl_q[g][CTRL_ACTION_LSB +: CTRL_ACTION_W]),
                .single_run(ctrl_q[g][CTRL_SINGLE_BIT]),
                .retrigger(ctrl_q[g][CTRL_RETRIG_BIT]),
                .internal_src(ctrl_q[g][CTRL_INTSRC_BIT] && !(g == 1 && link == LINK_TO_CLOCK_INPUT)),
                .init_count(load_q[g]),
                .count_in(src_sel),
                .gate_in(gate_sel),
                .trig_in(trig_sel),
                .count_q(count[g]),
                .running(running[g]),
                .out_q(ctr_out[g]),
                .terminal_q(terminal[g])
            );
        end
    endgenerate

endmodule // linked_down_counter_trio

// [dv/ldct_sva.sv]
// Port-level checker for the three-channel linked down counter.
// Assumes the register map and one-cycle read latency of the design package.
`timescale 1ns/1ps

module ldct_sva
    import ldct_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS,
    parameter int WIDTH = COUNT_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    // Counter pins
    input wire logic [CHANNELS-1:0] count_in,
    input wire logic [CHANNELS-1:0] gate_in,
    input wire logic [CHANNELS-1:0] trig_in,
    input wire logic [CHANNELS-1:0] ctr_out
);
    // ========================================================================
    // Shadow of control writes, so properties know the selected modes
    logic [5:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d;
    logic [1:0] link_q, link_d;
    always_comb begin
        ctl0_d = (wr_en && addr == 8'h00) ? wdata[5:0] : ctl0_q;
        ctl1_d = (wr_en && addr == 8'h10) ? wdata[5:0] : ctl1_q;
        link_d = (wr_en && addr == LINK_OFS) ? wdata[1:0] : link_q;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0_q <= '0;
            ctl1_q <= '0;
            link_q <= '0;
        end else begin
            ctl0_q <= ctl0_d;
            ctl1_q <= ctl1_d;
            link_q <= link_d;
        end
    end

    // ========================================================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Trigger and writes must stay quiet long enough to tell a stop from a slow count
    sequence quiet_s;
        (!trig_in[0] && !wr_en) [*4];
    endsequence
    sequence fin_s;
        ctl0_q[3] && ctl0_q[2:1] == 2'd2 && $fell(ctr_out[0]);
    endsequence

    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == '0) else $error("rdata not zero outside read");
    a_status_read: assert property (rd_en && addr == STATUS_OFS |=> rdata[2:0] == $past(ctr_out))
        else $error("status read does not show outputs");
    a_pulse_width: assert property (ctl0_q[2:1] == 2'd0 && $rose(ctr_out[0]) |=> $fell(ctr_out[0]))
        else $error("pulse output not one cycle");
    a_toggle_holds: assert property (ctl0_q[2:0] == 3'b011 && $changed(ctr_out[0]) |=> $stable(ctr_out[0]))
        else $error("toggle output changed twice in a row");
    a_high_start: assert property (wr_en && addr == 8'h00 && !ctl0_q[0] && wdata[2:0] == 3'b101
        |=> ##1 ctr_out[0]) else $error("high until terminal did not rise at start");
    a_single_stops: assert property (fin_s ##1 quiet_s |-> !ctr_out[0])
        else $error("single run restarted by itself");
    a_gate_blocks: assert property (link_q == 2'd1 && ctl1_q[2:1] == 2'd1 && !ctr_out[0]
        && !$past(ctr_out[0]) |-> $stable(ctr_out[1])) else $error("gated channel counted");
    // Channel 2 on its own pin source: without pin edges, pulses of channel 1 must not reach it
    a_unlinked_idle: assert property (link_q == 2'd0 && ctl1_q == 6'h01 && !count_in[1]
        && !$past(count_in[1]) |-> !ctr_out[1]) else $error("unlinked channel 2 counted without edges");
endmodule // ldct_sva

bind linked_down_counter_trio ldct_sva #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) u_sva (.mclk(mclk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .count_in(count_in),
    .gate_in(gate_in), .trig_in(trig_in), .ctr_out(ctr_out));

// [dv/linked_down_counter_trio_tb.sv]
// Self-checking bench for the three-channel linked down counter.
// Assumes the register map and timing of the design package and hand-over.
`timescale 1ns/1ps

module linked_down_counter_trio_tb;
    import ldct_pkg::*;
    logic mclk, rst_n, wr_en, rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d, r;
    logic [2:0] count_in, gate_in, trig_in, ctr_out;
    logic [31:0] ctl1_tab [4] = '{32'h01, 32'h23, 32'h3d, 32'h01};
    int miscompares, n_compared, n, g;

    linked_down_counter_trio dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .count_in(count_in), .gate_in(gate_in), .trig_in(trig_in), .ctr_out(ctr_out));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ========================================================================
    // Bus, compare and measurement tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    // Cycles until channel output changes; 100 means it never did
    task automatic gap(input int ch, output int k);
        logic v;
        v = ctr_out[ch];
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (ctr_out[ch] === v && k < 100);
    endtask
    task automatic pulse_trig();
        @(posedge mclk);
        trig_in[0] <= 1'b1;
        @(posedge mclk);
        trig_in[0] <= 1'b0;
    endtask
    // Edges that gap counts for a level of len cycles when it starts late edges after the change
    function automatic int span(input int len, input int late);
        return len - late;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        void'($urandom(32'ha8fb25fd));
        {rst_n, wr_en, rd_en, addr, wdata, count_in, trig_in} = '0;
        gate_in = 3'b111;
        miscompares = 0;
        n_compared = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 8'h40; a += 4) begin
            rd(8'(a), d);
            cmp("reset_or_unmapped", 0, d);
        end
        for (int c = 0; c < 3; c++) begin
            r = $urandom;
            wr(8'(c * 16 + 4), r);
            rd(8'(c * 16 + 4), d);
            cmp("load", r & 32'hffff, d);
            wr(8'(c * 16), r & 32'h3e);
            rd(8'(c * 16), d);
            cmp("ctrl", r & 32'h3e, d);
        end
        repeat (2) begin
            n = 2 + $urandom % 5;
            wr(8'h00, 0);
            wr(8'h04, 32'(n));
            wr(8'h00, 32'h21);
            gap(0, g);
            cmp("first_terminal", n + 1, g);
            gap(0, g);
            cmp("pulse_width", 1, g);
            gap(0, g);
            cmp("reload_period", span(n, 1), g);
            wr(8'h00, 0);
            wr(8'h00, 32'h23);
            gap(0, g);
            gap(0, g);
            cmp("toggle_period", n, g);
            wr(8'h00, 0);
            wr(8'h00, 32'h2d);
            gap(0, g);
            cmp("high_at_start", 1, g);
            gap(0, g);
            cmp("high_length", n, g);
            gap(0, g);
            pulse_trig();
            gap(0, g);
            cmp("single_stopped", 100, g);
            rd(STATUS_OFS, d);
            cmp("running", 0, 32'(d[4]));
            wr(8'h00, 32'h3d);
            pulse_trig();
            gap(0, g);
            cmp("retrigger_rise", 1, g);
            gap(0, g);
            // The rise lands on the trigger's sampling edge, one edge before gap starts counting
            cmp("retrigger_pin", span(n, 1), g);
            wr(SWTRIG_OFS, 32'h1);
            gap(0, g);
            gap(0, g);
            cmp("retrigger_soft", n, g);
        end
        for (int l = 0; l < 4; l++) begin
            wr(8'h00, 0);
            wr(8'h10, 0);
            wr(FLAGS_OFS, 32'h7);
            wr(LINK_OFS, 32'(l));
            wr(8'h14, 32'h4);
            wr(8'h04, 32'h3);
            wr(8'h10, ctl1_tab[l]);
            wr(8'h00, l == 1 ? 32'h0 : 32'h21);
            repeat (30) @(posedge mclk);
            rd(FLAGS_OFS, d);
            if (l == 2)
                cmp("linked_trigger", 1, 32'(ctr_out[1]));
            else
                cmp("linked_flag", 32'(l == 3), 32'(d[1]));
        end
        // External source on channel 3: pin edges count only while its gate pin is high
        wr(8'h24, 32'h3);
        wr(8'h20, 32'h01);
        gate_in[2] <= 1'b0;
        repeat (8) @(posedge mclk) count_in[2] <= ~count_in[2];
        rd(8'h28, d);
        cmp("gated_count", 3, d);
        @(posedge mclk) gate_in[2] <= 1'b1;
        repeat (4) @(posedge mclk) count_in[2] <= ~count_in[2];
        rd(8'h28, d);
        cmp("pin_count", 1, d);
        tally_and_finish();
    end

    initial begin
        #(40 * 8000);
        miscompares++;
        tally_and_finish();
    end
endmodule // linked_down_counter_trio_tb
